/* rtl/sar_adc_ctrl_params.svh */
// Register map, field positions, reset values and counts of the converter.
`ifndef SAR_ADC_CTRL_PARAMS_SVH
`define SAR_ADC_CTRL_PARAMS_SVH

`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_RES_HIGH   8'h08
`define OFS_RES_LOW    8'h0c
`define OFS_ASEL_LOW   8'h10
`define OFS_ASEL_HIGH  8'h14
`define OFS_STATUS     8'h18
`define OFS_MASK       8'h1c

`define C0_EN          0
`define C0_GO          1
`define C0_CHAN        5:2
`define C0_CLK         7:6
`define C1_FMT         0
`define C1_VPOS        1
`define C1_VNEG        2
`define ST_DONE        0

`define ASEL_LOW_RST   8'hff
`define ASEL_HIGH_RST  6'h3f

`define DIV2_LAST      5'h01
`define DIV8_LAST      5'h07
`define DIV32_LAST     5'h1f

`define SAR_MSB        10'h200
`define TOTAL_TADS     4'hb
`define ABORT_LAST     2'h1

`endif

/* rtl/sar_adc_pkg.sv */
// Types shared by the converter control logic.
package sar_adc_pkg;
   typedef enum logic [2:0] {st_idle, st_sync, st_hold, st_bits, st_abort}
      conv_state_t;
   typedef enum logic [1:0] {clk_div2, clk_div8, clk_div32, clk_rc}
      conv_clk_t;
endpackage

/* rtl/sar_adc_ctrl.sv */
// Successive-approximation converter control with an APB register file.
// Notes on behaviour
// - Each conversion yields a 10-bit value by successive approximation, kept readable.
// - The channel field picks which analog input feeds the shared sample-and-hold.
// - Clock select 00, 01, 10 divide the system clock by 2, 8, 32; 11 uses RC.
// - A bit-period resolves one bit; a whole conversion lasts 11 bit-periods.
// - Divided selections come straight from the system clock and track its rate.
// - After go, sync to bit-period, open the hold switch, resolve b9 to b0.
// - At the end load result, clear go, set done flag, reconnect the hold.
// - Completion can request an interrupt that may also wake a sleeping processor.
// - Positive reference is supply or pin; negative is ground or pin.
// - Conversions run only while enabled; setting go starts one.
// - Clearing go mid-conversion keeps the old result and waits 2 bit-periods.
// - The format bit places the result left or right justified.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "sar_adc_ctrl_params.svh"

module sar_adc_ctrl
(
   // Clock, reset and clock enable.
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Analog front end.
   input  wire logic        rc_osc_tick,
   input  wire logic        comp_above,
   output logic [3:0]       chan_sel,
   output logic             hold_connect,
   output logic [9:0]       trial_code,
   output logic             vref_pos_ext,
   output logic             vref_neg_ext,
   output logic [13:0]      analog_pin_sel,
   // Interrupt and wake request.
   output logic             irq
);
   import sar_adc_pkg::*;

   logic        en_q, go_q, fmt_q, vpos_q, vneg_q, done_q, mask_q;
   logic        cap_q, irq_q, pready_q, pslverr_q;
   logic [3:0]  chan_q, tad_q;
   logic [7:0]  asel_lo_q;
   logic [5:0]  asel_hi_q;
   logic [9:0]  result_q, trial_q, bit_q;
   logic [4:0]  div_q;
   logic [1:0]  abort_q;
   logic [31:0] prdata_q;
   conv_clk_t   clksel_q;
   conv_state_t state_q, state_d;

   function automatic logic [4:0] div_last(input conv_clk_t sel);
      case (sel)
         clk_div2:  div_last = `DIV2_LAST;
         clk_div8:  div_last = `DIV8_LAST;
         default:   div_last = `DIV32_LAST;
      endcase
   endfunction

   // Bus decode.
   wire setup    = psel & ~penable;
   wire wr_acc   = psel & penable & pwrite & pready_q;
   wire hit_c0   = paddr == `OFS_CTRL0;
   wire hit_c1   = paddr == `OFS_CTRL1;
   wire hit_rhi  = paddr == `OFS_RES_HIGH;
   wire hit_rlo  = paddr == `OFS_RES_LOW;
   wire hit_alo  = paddr == `OFS_ASEL_LOW;
   wire hit_ahi  = paddr == `OFS_ASEL_HIGH;
   wire hit_st   = paddr == `OFS_STATUS;
   wire hit_mk   = paddr == `OFS_MASK;
   wire unmapped = ~(hit_c0 | hit_c1 | hit_rhi | hit_rlo | hit_alo |
                     hit_ahi | hit_st | hit_mk);
   wire wr_ctrl0 = wr_acc & hit_c0;
   wire wr_ctrl1 = wr_acc & hit_c1;
   wire wr_stat  = wr_acc & hit_st;

   // Result pair as software sees it.
   wire [7:0] res_hi_v = fmt_q ? {6'h00, result_q[9:8]} : result_q[9:2];
   wire [7:0] res_lo_v = fmt_q ? result_q[7:0] : {result_q[1:0], 6'h00};
   wire [7:0] c0_v     = {clksel_q, chan_q, go_q, en_q};
   wire [7:0] c1_v     = {5'h00, vneg_q, vpos_q, fmt_q};
   wire [7:0] rd_byte  = hit_c0  ? c0_v :
                         hit_c1  ? c1_v :
                         hit_rhi ? res_hi_v :
                         hit_rlo ? res_lo_v :
                         hit_alo ? asel_lo_q :
                         hit_ahi ? {2'h0, asel_hi_q} :
                         hit_st  ? {7'h00, done_q} :
                         hit_mk  ? {7'h00, mask_q} : 8'h00;

   // Bit-period tick from the divider or the RC oscillator.
   wire [4:0] last     = div_last(clksel_q);
   wire       div_wrap = div_q >= last;
   wire       tick     = ce & ((clksel_q == clk_rc) ? rc_osc_tick
                                                    : div_wrap);

   // Go flag control; a set always wins over a clear.
   wire run_ok   = go_q & en_q;
   wire go_set   = wr_ctrl0 & pwdata[`C0_GO] & en_q;
   wire go_clr   = wr_ctrl0 & ~pwdata[`C0_GO];
   wire [9:0] trial_keep = comp_above ? trial_q : (trial_q & ~bit_q);
   wire conv_end = (state_q == st_bits) & tick & bit_q[0] & run_ok;
   wire go_d     = ~en_q ? 1'b0 :
                   go_set ? 1'b1 :
                   (conv_end | go_clr) ? 1'b0 : go_q;
   wire done_d   = conv_end |
                   (done_q & ~(wr_stat & pwdata[`ST_DONE]));

   // Conversion sequencer.
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         st_idle:
            if (run_ok)
               state_d = st_sync;
         st_sync:
            if (!run_ok)
               state_d = st_idle;
            else if (tick)
               state_d = st_hold;
         st_hold:
            if (!run_ok)
               state_d = st_abort;
            else if (tick)
               state_d = st_bits;
         st_bits:
            if (!run_ok)
               state_d = st_abort;
            else if (tick && bit_q[0])
               state_d = st_idle;
         st_abort:
            if (tick && abort_q == `ABORT_LAST)
               state_d = st_idle;
         default:
            state_d = st_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= st_idle;
         div_q   <= 5'h00;
         abort_q <= 2'h0;
         tad_q   <= 4'h0;
         cap_q   <= 1'b1;
         trial_q <= 10'h000;
         bit_q   <= 10'h000;
         result_q <= 10'h000;
      end
      else if (ce)
      begin
         state_q <= state_d;
         div_q   <= div_wrap ? 5'h00 : div_q + 5'h01;
         if (state_q == st_sync && state_d == st_hold)
         begin
            cap_q   <= 1'b0;
            trial_q <= `SAR_MSB;
            bit_q   <= `SAR_MSB;
            tad_q   <= 4'h1;
         end
         else if (state_q == st_hold && state_d == st_bits)
            tad_q <= tad_q + 4'h1;
         else if (state_q == st_bits && state_d == st_bits && tick)
         begin
            trial_q <= trial_keep | (bit_q >> 1);
            bit_q   <= bit_q >> 1;
            tad_q   <= tad_q + 4'h1;
         end
         if (conv_end)
         begin
            result_q <= trial_keep;
            cap_q    <= 1'b1;
         end
         if (state_q != st_abort)
            abort_q <= 2'h0;
         else if (tick)
            abort_q <= abort_q + 2'h1;
         if (state_q == st_abort && state_d == st_idle)
            cap_q <= 1'b1;
      end
   end

   // Software registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_q      <= 1'b0;
         go_q      <= 1'b0;
         chan_q    <= 4'h0;
         clksel_q  <= clk_div2;
         fmt_q     <= 1'b0;
         vpos_q    <= 1'b0;
         vneg_q    <= 1'b0;
         asel_lo_q <= `ASEL_LOW_RST;
         asel_hi_q <= `ASEL_HIGH_RST;
         done_q    <= 1'b0;
         mask_q    <= 1'b0;
      end
      else if (ce)
      begin
         go_q   <= go_d;
         done_q <= done_d;
         if (wr_ctrl0)
         begin
            en_q     <= pwdata[`C0_EN];
            chan_q   <= pwdata[`C0_CHAN];
            clksel_q <= conv_clk_t'(pwdata[`C0_CLK]);
         end
         if (wr_ctrl1)
         begin
            fmt_q  <= pwdata[`C1_FMT];
            vpos_q <= pwdata[`C1_VPOS];
            vneg_q <= pwdata[`C1_VNEG];
         end
         if (wr_acc && hit_alo)
            asel_lo_q <= pwdata[7:0];
         if (wr_acc && hit_ahi)
            asel_hi_q <= pwdata[5:0];
         if (wr_acc && hit_mk)
            mask_q <= pwdata[`ST_DONE];
      end
   end

   // Bus answer and interrupt line.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
         irq_q     <= 1'b0;
      end
      else if (ce)
      begin
         pready_q  <= setup;
         pslverr_q <= setup & unmapped;
         if (setup)
            prdata_q <= {24'h00_0000, rd_byte};
         irq_q <= done_q & mask_q;
      end
   end

   assign pready         = pready_q;
   assign prdata         = prdata_q;
   assign pslverr        = pslverr_q;
   assign irq            = irq_q;
   assign chan_sel       = chan_q;
   assign hold_connect   = cap_q;
   assign trial_code     = trial_q;
   assign vref_pos_ext   = vpos_q;
   assign vref_neg_ext   = vneg_q;
   assign analog_pin_sel = {asel_hi_q, asel_lo_q};

   chk_go_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (!en_q && ce) |=> (!go_q && $stable(result_q)))
      else $error("go set while disabled");
   chk_done_load: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_end && !go_set) |=>
         (!go_q && cap_q && done_q && result_q == $past(trial_keep)))
      else $error("completion effects missing");
   chk_hold_open: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == st_bits || state_q == st_hold) |-> !cap_q)
      else $error("hold switch closed during conversion");
   chk_tad_count: assert property (@(posedge pclk) disable iff (!presetn)
      conv_end |-> tad_q == `TOTAL_TADS)
      else $error("conversion not eleven bit periods");
   chk_div8_gap: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && clksel_q == clk_div8 && !wr_ctrl0) |=> !tick [*7])
      else $error("divide by eight tick spacing wrong");
   chk_abort_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == st_abort) |=> $stable(result_q))
      else $error("result changed by abort");
   chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> irq_q == $past(done_q & mask_q))
      else $error("interrupt level wrong");
   chk_fmt_right: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && setup && hit_rhi && fmt_q) |=> prdata_q[7:2] == 6'h00)
      else $error("right justified high byte not clear");
   chk_chan_route: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr_ctrl0) |=> chan_sel == $past(pwdata[`C0_CHAN]))
      else $error("channel select not routed");

endmodule

/* tb/sar_front_model.sv */
// Behavioural analog front end: sample-and-hold, comparator and RC ticks.
`timescale 1ns/1ps
module sar_front_model
#(
   parameter int RC_DIV = 20
)
(
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Converter side.
   input  wire logic [3:0] chan_sel,
   input  wire logic       hold_connect,
   input  wire logic [9:0] trial_code,
   output logic            comp_above,
   output logic            rc_osc_tick
);
   logic [9:0] level [16];
   logic [9:0] held_q;
   int         rc_q;
   // The capacitor follows the selected input only while connected.
   always_ff @(posedge pclk)
      if (hold_connect)
         held_q <= level[chan_sel];
   assign comp_above = held_q >= trial_code;
   // The oscillator ticks once every RC_DIV cycles of the system clock.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         rc_q <= 0;
      else
         rc_q <= (rc_q == RC_DIV - 1) ? 0 : rc_q + 1;
   assign rc_osc_tick = rc_q == RC_DIV - 1;
endmodule

/* tb/sar_adc_conversion_control_tb_top.sv */
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
`include "sar_adc_ctrl_params.svh"
module sar_adc_conversion_control_tb_top;
   import sar_adc_pkg::*;
   localparam int RC_DIV = 20;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic        irq, comp_above, rc_osc_tick, hold_connect, last_err;
   logic        vref_pos_ext, vref_neg_ext;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, seed, v, keep;
   logic [3:0]  chan_sel;
   logic [9:0]  trial_code;
   logic [13:0] analog_pin_sel;
   logic [15:0] res;
   int          error_cnt, check_count, run, last_low, n;
   sar_adc_ctrl u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .rc_osc_tick,
      .comp_above, .chan_sel, .hold_connect, .trial_code, .vref_pos_ext,
      .vref_neg_ext, .analog_pin_sel, .irq);
   sar_front_model #(.RC_DIV(RC_DIV)) u_fe (.pclk, .presetn, .chan_sel,
      .hold_connect, .trial_code, .comp_above, .rc_osc_tick);
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Length of each stretch with the hold switch open.
   always @(negedge pclk)
      if (!hold_connect)
         run <= run + 1;
      else
      begin
         if (run != 0)
            last_low <= run;
         run <= 0;
      end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int per(input logic [1:0] cs);
      return cs == 2'h0 ? 2 : cs == 2'h1 ? 8 : cs == 2'h2 ? 32 : RC_DIV;
   endfunction
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      // Answer and read data are taken at the edge that samples pready.
      do
      begin
         @(posedge pclk);
         k++;
         if (k > 50)
         begin
            error_cnt++;
            finish_test();
         end
      end
      while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic start(input logic [1:0] cs, input logic [9:0] lv);
      logic [3:0] ch;
      ch = 4'(rnd());
      u_fe.level[ch] = lv;
      apb(1'b1, `OFS_STATUS, 32'h1, q);
      apb(1'b1, `OFS_CTRL0, {24'h0, cs, ch, 2'b01}, q);
      repeat (20) @(posedge pclk);
      chk(chan_sel, ch);
      apb(1'b1, `OFS_CTRL0, {24'h0, cs, ch, 2'b11}, q);
   endtask
   task automatic convert(input logic [1:0] cs, input logic [9:0] lv);
      logic f;
      f = 1'(rnd());
      apb(1'b1, `OFS_CTRL1, {29'h0, lv[1:0], f}, q);
      @(negedge pclk);
      chk({vref_neg_ext, vref_pos_ext}, lv[1:0]);
      start(cs, lv);
      n = 0;
      do
      begin
         apb(1'b0, `OFS_CTRL0, 32'h0, q);
         n++;
      end
      while (q[1] !== 1'b0 && n < 400);
      chk(n < 400, 1'b1);
      @(negedge pclk);
      chk(last_low, 11 * per(cs));
      res = f ? {6'h00, lv} : {lv, 6'h00};
      apb(1'b0, `OFS_RES_HIGH, 32'h0, q);
      chk(q, res[15:8]);
      apb(1'b0, `OFS_RES_LOW, 32'h0, q);
      chk(q, res[7:0]);
      apb(1'b0, `OFS_STATUS, 32'h0, q);
      chk(q, 32'h1);
   endtask
   initial
   begin
      seed = 32'h87c784e7;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      run = 0;
      last_low = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk(analog_pin_sel, 14'h3fff);
      for (int a = 0; a < 9; a++)
      begin
         apb(1'b0, 8'(a * 4), 32'h0, q);
         chk(q, a == 4 ? 32'hff : a == 5 ? 32'h3f : 32'h0);
         chk(last_err, a == 8);
      end
      keep = rnd();
      apb(1'b1, `OFS_ASEL_LOW, keep, q);
      v = rnd();
      apb(1'b1, `OFS_ASEL_HIGH, v, q);
      @(negedge pclk);
      chk(analog_pin_sel, {v[5:0], keep[7:0]});
      apb(1'b1, `OFS_CTRL0, 32'h2, q);
      apb(1'b0, `OFS_CTRL0, 32'h0, q);
      chk(q, 32'h0);
      chk(hold_connect, 1'b1);
      for (int i = 0; i < 8; i++)
         convert(2'(i), i == 0 ? 10'h3ff : i == 1 ? 10'h000 : 10'(rnd()));
      apb(1'b1, `OFS_MASK, 32'h1, q);
      repeat (2) @(negedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, `OFS_STATUS, 32'h1, q);
      repeat (2) @(negedge pclk);
      chk(irq, 1'b0);
      apb(1'b0, `OFS_RES_LOW, 32'h0, q);
      chk(q, res[7:0]);
      start(2'h2, ~u_fe.level[chan_sel]);
      repeat (100) @(posedge pclk);
      apb(1'b1, `OFS_CTRL0, {24'h0, 2'h2, chan_sel, 2'b01}, q);
      n = 0;
      while (hold_connect !== 1'b1 && n < 100)
      begin
         @(negedge pclk);
         n++;
      end
      chk(n > 28 && n < 68, 1'b1);
      apb(1'b0, `OFS_RES_LOW, 32'h0, q);
      chk(q, res[7:0]);
      chk(irq, 1'b0);
      finish_test();
   end
   initial
   begin
      repeat (100000) @(posedge pclk);
      error_cnt++;
      finish_test();
   end
endmodule
